// ==== rtl/twowire_slave.sv ====
/*
 * two-wire hardware slave with software master mode and Avalon-MM registers
 * assumes open-drain pads outside: *_oe high with *_out low pulls the line low
 */
`timescale 1ns/10ps
module twowire_slave
   import twowire_pkg::*;
#(
   parameter int FILT_CYC = SPIKE_CYC
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output logic             o_scl_out,
   output logic             o_scl_oe,
   output logic             o_sda_out,
   output logic             o_sda_oe,
   output logic             o_irq,
   output logic [7:0]       o_irq_vector
);
   // =========================================================
   // registers and state
   logic [7:0]   data_q, own_a_q, own_b_q, shift_q;
   logic         sdo_q, sde_q, sco_q, sdi_q, msel_q, irst_q, dir_q, done_q;
   logic         spe_q, ie_tw_q, ie_glob_q;
   logic         acc_q, ack_pending_q;
   logic [2:0]   bit_q;
   slave_state_t st_q;
   line_pair_t   s1_q, s2_q, f_q, fp_q;
   logic [3:0]   cnt_scl_q, cnt_sda_q;
   logic         done_pulse, buf_access, active;
   logic         scl_rise, scl_fall, start_c, stop_c;
   logic         wr_hit, rd_hit;

   assign active     = !spe_q && !msel_q;
   assign wr_hit     = i_avs_write && o_avs_waitrequest;
   assign rd_hit     = i_avs_read && o_avs_waitrequest;
   assign buf_access = (wr_hit || rd_hit) && i_avs_address == ADDR_DATA;
   assign scl_rise   = f_q.scl && !fp_q.scl;
   assign scl_fall   = !f_q.scl && fp_q.scl;
   assign start_c    = f_q.scl && fp_q.scl && fp_q.sda && !f_q.sda;
   assign stop_c     = f_q.scl && fp_q.scl && !fp_q.sda && f_q.sda;

   // =========================================================
   // two-flop synchroniser on both lines
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         s1_q <= '1;
         s2_q <= '1;
      end
      else
      begin
         s1_q <= '{scl: i_scl, sda: i_sda};
         s2_q <= s1_q;
      end
   end

   // spike filter: a level must hold FILT_CYC cycles to pass
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         f_q       <= '1;
         fp_q      <= '1;
         cnt_scl_q <= '0;
         cnt_sda_q <= '0;
      end
      else
      begin
         fp_q <= f_q;
         if (s2_q.scl == f_q.scl)
            cnt_scl_q <= '0;
         else if (cnt_scl_q == 4'(FILT_CYC - 1))
         begin
            f_q.scl   <= s2_q.scl;
            cnt_scl_q <= '0;
         end
         else
            cnt_scl_q <= cnt_scl_q + 4'h1;
         if (s2_q.sda == f_q.sda)
            cnt_sda_q <= '0;
         else if (cnt_sda_q == 4'(FILT_CYC - 1))
         begin
            f_q.sda   <= s2_q.sda;
            cnt_sda_q <= '0;
         end
         else
            cnt_sda_q <= cnt_sda_q + 4'h1;
      end
   end

   // =========================================================
   // Avalon slave: one wait cycle, then answer
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= '0;
      end
      else
      begin
         o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
         if (rd_hit)
         begin
            case (i_avs_address)
               ADDR_DATA:    o_avs_readdata <= {24'h0, data_q};
               ADDR_CONTROL: o_avs_readdata <= {24'h0, sdo_q, sde_q, sco_q, sdi_q,
                                                msel_q, irst_q, dir_q, done_q};
               ADDR_OWN_A:   o_avs_readdata <= {24'h0, own_a_q};
               ADDR_OWN_B:   o_avs_readdata <= {24'h0, own_b_q};
               ADDR_SPI_CTL: o_avs_readdata <= {26'h0, spe_q, 5'h0};
               ADDR_INT_EN:  o_avs_readdata <= {30'h0, ie_glob_q, ie_tw_q};
               default:      o_avs_readdata <= '0;
            endcase
         end
      end
   end

   // software written configuration
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         {sdo_q, sde_q, sco_q, msel_q, irst_q} <= '0;
         own_a_q   <= RST_OWN_A;
         own_b_q   <= RST_OWN_B;
         spe_q     <= 1'b0;
         ie_tw_q   <= 1'b0;
         ie_glob_q <= 1'b0;
      end
      else if (wr_hit)
      begin
         case (i_avs_address)
            ADDR_CONTROL:
            begin                                                    // done bit not writable
               sdo_q  <= i_avs_writedata[CTL_SDO];
               sde_q  <= i_avs_writedata[CTL_SDE];
               sco_q  <= i_avs_writedata[CTL_SCO];
               msel_q <= i_avs_writedata[CTL_MSEL];
               irst_q <= i_avs_writedata[CTL_IRST];
            end
            ADDR_OWN_A:   own_a_q   <= i_avs_writedata[7:0];
            ADDR_OWN_B:   own_b_q   <= i_avs_writedata[7:0];
            ADDR_SPI_CTL: spe_q     <= i_avs_writedata[SPI_SPE];
            ADDR_INT_EN:
            begin
               ie_tw_q   <= i_avs_writedata[IE_TW];
               ie_glob_q <= i_avs_writedata[IE_GLOB];
            end
            default: ;
         endcase
      end
   end

   // software master data input sampled on rising clock line
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
         sdi_q <= 1'b0;
      else if (!sde_q && scl_rise)
         sdi_q <= f_q.sda;
   end

   // =========================================================
   // slave controller
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n || irst_q || !active)
      begin
         st_q          <= ST_IDLE;
         bit_q         <= '0;
         shift_q       <= '0;
         dir_q         <= 1'b0;
         ack_pending_q <= 1'b0;
         done_pulse    <= 1'b0;
      end
      else
      begin
         done_pulse <= 1'b0;
         if (stop_c && st_q != ST_HALT)
            st_q <= ST_IDLE;
         else if (start_c && st_q != ST_HALT)
         begin
            st_q  <= ST_ADDR;
            bit_q <= '0;
         end
         else
         begin
            case (st_q)
               ST_IDLE: ;
               ST_ADDR:
                  if (scl_rise)
                  begin
                     shift_q <= {shift_q[6:0], f_q.sda};
                     bit_q   <= bit_q + 3'h1;
                     if (bit_q == 3'h7)
                     begin
                        if ({shift_q[6:0]} == own_a_q[6:0] ||
                            {shift_q[6:0]} == own_b_q[6:0])
                           st_q <= ST_AACK;
                        else
                           st_q <= ST_IDLE;
                        dir_q <= f_q.sda;
                     end
                  end
               // first fall starts the ack, second fall ends it and flags the address
               ST_AACK:
                  if (scl_fall && !ack_pending_q)
                     ack_pending_q <= 1'b1;
                  else if (scl_fall)
                     done_pulse    <= 1'b1;
                  else if (done_pulse)
                  begin
                     ack_pending_q <= 1'b0;
                     st_q <= dir_q ? ST_TX : ST_RX;
                  end
               ST_RX, ST_TX:
                  if (scl_rise)
                  begin
                     shift_q <= {shift_q[6:0], f_q.sda};
                     bit_q   <= bit_q + 3'h1;
                     if (bit_q == 3'h7)
                        st_q <= ST_DACK;
                  end
               ST_DACK:
                  if (scl_rise)
                  begin
                     if (!f_q.sda)
                     begin
                        done_pulse <= 1'b1;
                        st_q <= dir_q ? ST_TX : ST_RX;
                     end
                     else
                        st_q <= ST_IDLE;
                  end
               ST_HALT: ;
               default: st_q <= ST_IDLE;
            endcase
            if (buf_access && acc_q)
               st_q <= ST_HALT;
         end
      end
   end

   // byte-done flag and data buffer; set wins over clear
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         done_q <= 1'b0;
         acc_q  <= 1'b0;
         data_q <= RST_DATA;
      end
      else
      begin
         if (done_pulse)
         begin
            done_q <= 1'b1;
            acc_q  <= 1'b0;
            if (!dir_q || st_q == ST_AACK)
               data_q <= shift_q;
         end
         else if (buf_access)
         begin
            done_q <= 1'b0;
            acc_q  <= 1'b1;
            if (wr_hit)
               data_q <= i_avs_writedata[7:0];
         end
      end
   end

   // =========================================================
   // pin drive: master mode from software bits, slave mode open drain
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         o_scl_out <= 1'b1;
         o_scl_oe  <= 1'b0;
         o_sda_out <= 1'b1;
         o_sda_oe  <= 1'b0;
      end
      else if (!spe_q && msel_q)
      begin
         o_scl_oe  <= 1'b1;
         o_scl_out <= sco_q;
         o_sda_oe  <= sde_q;
         o_sda_out <= sdo_q;
      end
      else
      begin
         o_scl_out <= 1'b0;
         o_sda_out <= 1'b0;
         o_scl_oe  <= active && done_q && !f_q.scl &&
                      (st_q == ST_AACK || st_q == ST_RX || st_q == ST_TX ||
                       st_q == ST_DACK);
         if (st_q == ST_AACK && !ack_pending_q && !f_q.scl)
            o_sda_oe <= 1'b1;
         else if (st_q == ST_RX && bit_q == 3'h0 && ack_pending_q)
            o_sda_oe <= 1'b0;
         else if (st_q == ST_DACK && !dir_q)
            o_sda_oe <= !f_q.scl || o_sda_oe;
         else if (st_q == ST_TX && !f_q.scl)
            o_sda_oe <= !data_q[3'h7 - bit_q];
         else if (scl_fall || st_q == ST_IDLE || st_q == ST_HALT)
            o_sda_oe <= 1'b0;
      end
   end

   // interrupt request gated by both enables
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         o_irq        <= 1'b0;
         o_irq_vector <= IRQ_VECTOR;
      end
      else
      begin
         o_irq        <= done_q && ie_tw_q && ie_glob_q && !buf_access;
         o_irq_vector <= IRQ_VECTOR;
      end
   end

   // =========================================================
   property p_irq_gate;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_irq |-> $past(ie_tw_q) && $past(ie_glob_q) && $past(done_q);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

   property p_clear;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (buf_access && !done_pulse) |=> !done_q;
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");

   property p_master_scl;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (msel_q && !spe_q) |=> o_scl_oe && o_scl_out == $past(sco_q);
   endproperty
   a_master_scl: assert property (p_master_scl) else $error("master clock wrong");

   property p_master_sda;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (msel_q && !spe_q) |=> o_sda_oe == $past(sde_q);
   endproperty
   a_master_sda: assert property (p_master_sda) else $error("master data enable");

   property p_irst;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      irst_q |=> st_q == ST_IDLE;
   endproperty
   a_irst: assert property (p_irst) else $error("not idle on reset bit");

   property p_spe;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      spe_q |=> st_q == ST_IDLE && !o_scl_oe;
   endproperty
   a_spe: assert property (p_spe) else $error("active with spi enabled");

   property p_halt;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (st_q == ST_HALT && !irst_q && active) |=> st_q == ST_HALT;
   endproperty
   a_halt: assert property (p_halt) else $error("halt left");

   property p_stop;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (stop_c && st_q != ST_HALT && active && !irst_q) |=> st_q == ST_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("stop ignored");
endmodule

// ==== rtl/twowire_pkg.sv ====
/*
 * shared constants and types for the two-wire slave and software master
 * assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus
 */
package twowire_pkg;
   // =========================================================
   // register byte addresses
   localparam logic [7:0] ADDR_DATA     = 8'h9A; // serial_data_buffer, printed offset
   localparam logic [7:0] ADDR_CONTROL  = 8'hE8; // twowire_control
   localparam logic [7:0] ADDR_OWN_A    = 8'h9C; // own_address_a
   localparam logic [7:0] ADDR_OWN_B    = 8'hF0; // own_address_b
   localparam logic [7:0] ADDR_SPI_CTL  = 8'hF8; // spi_control
   localparam logic [7:0] ADDR_INT_EN   = 8'hA8; // interrupt enables
   // =========================================================
   // reset values
   localparam logic [7:0] RST_DATA      = 8'h00;
   localparam logic [7:0] RST_OWN_A     = 8'h55;
   localparam logic [7:0] RST_OWN_B     = 8'h7F;
   // =========================================================
   // control field positions
   localparam int CTL_SDO  = 7;
   localparam int CTL_SDE  = 6;
   localparam int CTL_SCO  = 5;
   localparam int CTL_SDI  = 4;
   localparam int CTL_MSEL = 3;
   localparam int CTL_IRST = 2;
   localparam int CTL_DIR  = 1;
   localparam int CTL_DONE = 0;
   localparam int SPI_SPE  = 5;
   localparam int IE_TW    = 0;
   localparam int IE_GLOB  = 1;
   // =========================================================
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SPIKE_NS      = 50;
   localparam int SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] IRQ_VECTOR = 8'h3B;
   // =========================================================
   typedef struct packed
   {
      logic scl;
      logic sda;
   } line_pair_t;
   typedef enum logic [6:0]
   {
      ST_IDLE  = 7'b0000001,
      ST_ADDR  = 7'b0000010,
      ST_AACK  = 7'b0000100,
      ST_RX    = 7'b0001000,
      ST_TX    = 7'b0010000,
      ST_DACK  = 7'b0100000,
      ST_HALT  = 7'b1000000
   } slave_state_t;
endpackage

// ==== verification/twowire_master_model.sv ====
/*
 * behavioural two-wire bus master that drives open-drain lines
 * assumes the bench resolves both lines with pull-ups
 */
`timescale 1ns/10ps
module twowire_master_model
(
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_scl_low,
   output logic      o_sda_low
);
   // =========================================================
   // bus primitives
   // both lines released at start
   initial
   begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end
   // quarter of a 240 ns bit: halves must outlast the 50 ns line filter plus sync
   localparam int QTR = 60;
   // one clock pulse that waits out the slave's stretching
   task automatic pulse(input logic g, output logic s);
      int n = 0;
      #QTR o_scl_low = 1'b0;
      while (i_scl !== 1'b1 && n < 4000)
      begin
         #10 n++;
      end
      if (g)
      begin
         #30 o_sda_low = ~o_sda_low; // short spike under the filter width
         #24 o_sda_low = ~o_sda_low;
         #66;
      end
      else
         #120;
      s = i_sda;
      o_scl_low = 1'b1;
      #QTR;
   endtask
   // start: data falls while clock is high
   task automatic start_cond();
      o_sda_low = 1'b0;
      #QTR o_scl_low = 1'b0;
      #120 o_sda_low = 1'b1;
      #120 o_scl_low = 1'b1;
      #QTR;
   endtask
   // stop: data rises while clock is high
   task automatic stop_cond();
      o_sda_low = 1'b1;
      #QTR o_scl_low = 1'b0;
      #120 o_sda_low = 1'b0;
      #120;
   endtask
   // eight bits msb first, then sample the acknowledge
   task automatic write_byte(input logic [7:0] d, input logic g, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         o_sda_low = ~d[i];
         pulse(g && i == 7, s);
      end
      o_sda_low = 1'b0;
      pulse(1'b0, s);
      ack = ~s;
   endtask
   // eight bits in, then acknowledge or not
   task automatic read_byte(input logic nack, output logic [7:0] d);
      logic s;
      o_sda_low = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         pulse(1'b0, s);
         d[i] = s;
      end
      o_sda_low = ~nack;
      pulse(1'b0, s);
      o_sda_low = 1'b0;
   endtask
   // direct line holds for stretch and sampling checks
   task automatic hold(input logic c, input logic d);
      o_scl_low = c;
      o_sda_low = d;
   endtask
endmodule

// ==== verification/twowire_slave_tb.sv ====
/*
 * self-checking bench for the two-wire slave and software master
 * assumes the design package and a behavioural bus master model
 */
`timescale 1ns/10ps
module twowire_slave_tb;
   import twowire_pkg::*;
   localparam int         LIMIT  = 60000;
   localparam logic [7:0] B_SDO  = 8'(1 << CTL_SDO);
   localparam logic [7:0] B_SDE  = 8'(1 << CTL_SDE);
   localparam logic [7:0] B_SCO  = 8'(1 << CTL_SCO);
   localparam logic [7:0] B_MSEL = 8'(1 << CTL_MSEL);
   localparam logic [7:0] B_IRST = 8'(1 << CTL_IRST);
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        scl_out, scl_oe, sda_out, sda_oe, irq, m_scl_low, m_sda_low;
   logic [7:0]  irq_vector;
   wire         scl_w = ~m_scl_low & (~scl_oe | scl_out);
   wire         sda_w = ~m_sda_low & (~sda_oe | sda_out);
   int          mismatches = 0;
   int          n_compared = 0;
   int          cycles = 0;
   logic        ack;
   logic [7:0]  b;
   // =========================================================
   // clock, reset and instances
   always #4 sys_clk = ~sys_clk;
   twowire_slave twowire_slave_i (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
      .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
      .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
      .o_avs_waitrequest(avs_waitrequest), .i_scl(scl_w), .i_sda(sda_w),
      .o_scl_out(scl_out), .o_scl_oe(scl_oe), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .o_irq(irq), .o_irq_vector(irq_vector));
   twowire_master_model twowire_master_model_i (.i_scl(scl_w), .i_sda(sda_w),
      .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));
   // hang guard
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         mismatches++;
         results();
      end
   end
   // =========================================================
   // shared tasks
   task automatic results();
      $display("mismatches %0d compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0)
      begin
         @(posedge sys_clk);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q & {24'hFFFFFF, m}, {24'h000000, e});
   endtask
   task automatic settle();
      repeat (30) @(posedge sys_clk);
   endtask
   // =========================================================
   // scenarios
   task automatic t_reset();
      rdc(ADDR_DATA, 8'hFF, RST_DATA);
      rdc(ADDR_OWN_A, 8'hFF, RST_OWN_A);
      rdc(ADDR_OWN_B, 8'hFF, 8'h7F);
      rdc(ADDR_CONTROL, 8'hFF, 8'h00);
      wr(ADDR_CONTROL, 8'h01);
      rdc(ADDR_CONTROL, 8'h01, 8'h00);
      wr(8'h10, 8'hA5);
      rdc(8'h10, 8'hFF, 8'h00);
   endtask
   task automatic t_write_own_a();
      wr(ADDR_INT_EN, 8'h03);
      twowire_master_model_i.start_cond();
      twowire_master_model_i.write_byte({RST_OWN_A[6:0], 1'b0}, 1'b0, ack);
      chk(ack, 1'b1);
      settle();
      rdc(ADDR_CONTROL, 8'h03, 8'h01);
      chk(irq, 1'b1);
      chk(irq_vector, 8'h3B);
      twowire_master_model_i.hold(1'b0, 1'b0);
      settle();
      chk(scl_w, 1'b0);
      twowire_master_model_i.hold(1'b1, 1'b0);
      rdc(ADDR_DATA, 8'hFF, {RST_OWN_A[6:0], 1'b0});
      rdc(ADDR_CONTROL, 8'h01, 8'h00);
      chk(irq, 1'b0);
      twowire_master_model_i.write_byte(8'h3C, 1'b1, ack);
      chk(ack, 1'b1);
      settle();
      rdc(ADDR_CONTROL, 8'h01, 8'h01);
      rdc(ADDR_DATA, 8'hFF, 8'h3C);
      twowire_master_model_i.stop_cond();
   endtask
   task automatic t_read_own_b();
      wr(ADDR_INT_EN, 8'h01);
      twowire_master_model_i.start_cond();
      twowire_master_model_i.write_byte(8'hFF, 1'b0, ack);
      chk(ack, 1'b1);
      settle();
      rdc(ADDR_CONTROL, 8'h03, 8'h03);
      chk(irq, 1'b0);
      wr(ADDR_DATA, 8'hA5);
      rdc(ADDR_CONTROL, 8'h01, 8'h00);
      twowire_master_model_i.read_byte(1'b1, b);
      chk(b, 8'hA5);
      settle();
      rdc(ADDR_CONTROL, 8'h01, 8'h00);
      twowire_master_model_i.stop_cond();
   endtask
   task automatic t_refused();
      twowire_master_model_i.start_cond();
      twowire_master_model_i.write_byte(8'h24, 1'b0, ack);
      chk(ack, 1'b0);
      twowire_master_model_i.stop_cond();
      wr(ADDR_SPI_CTL, 8'(1 << SPI_SPE));
      twowire_master_model_i.start_cond();
      twowire_master_model_i.write_byte({RST_OWN_A[6:0], 1'b0}, 1'b0, ack);
      chk(ack, 1'b0);
      twowire_master_model_i.stop_cond();
      wr(ADDR_SPI_CTL, 8'h00);
      rdc(ADDR_CONTROL, 8'h01, 8'h00);
   endtask
   task automatic t_halt();
      twowire_master_model_i.start_cond();
      twowire_master_model_i.write_byte(8'hFE, 1'b0, ack);
      chk(ack, 1'b1);
      settle();
      rdc(ADDR_DATA, 8'hFF, 8'hFE);
      rdc(ADDR_DATA, 8'hFF, 8'hFE);
      twowire_master_model_i.write_byte(8'h11, 1'b0, ack);
      settle();
      rdc(ADDR_CONTROL, 8'h01, 8'h00);
      wr(ADDR_CONTROL, B_IRST);
      wr(ADDR_CONTROL, 8'h00);
      twowire_master_model_i.stop_cond();
      twowire_master_model_i.start_cond();
      twowire_master_model_i.write_byte({RST_OWN_A[6:0], 1'b0}, 1'b0, ack);
      chk(ack, 1'b1);
      settle();
      rdc(ADDR_DATA, 8'hFF, {RST_OWN_A[6:0], 1'b0});
      twowire_master_model_i.stop_cond();
   endtask
   // software sequences the lines bit by bit in master mode
   task automatic t_sw_master();
      wr(ADDR_CONTROL, B_MSEL | B_SDE | B_SDO);
      settle();
      chk({scl_oe, scl_out, sda_oe, sda_out}, 4'hB);
      wr(ADDR_CONTROL, B_MSEL | B_SDE | B_SCO);
      settle();
      chk({scl_oe, scl_out, sda_oe, sda_out}, 4'hE);
      twowire_master_model_i.hold(1'b0, 1'b1);
      wr(ADDR_CONTROL, B_MSEL);
      settle();
      wr(ADDR_CONTROL, B_MSEL | B_SCO);
      settle();
      rdc(ADDR_CONTROL, 8'h10, 8'h00);
      twowire_master_model_i.hold(1'b0, 1'b0);
      settle();
      rdc(ADDR_CONTROL, 8'h10, 8'h00);
      wr(ADDR_CONTROL, B_MSEL);
      settle();
      wr(ADDR_CONTROL, B_MSEL | B_SCO);
      settle();
      rdc(ADDR_CONTROL, 8'h10, 8'h10);
      wr(ADDR_CONTROL, 8'h00);
      settle();
      chk({scl_oe, sda_oe}, 2'b00);
   endtask
   // =========================================================
   // main sequence
   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_write_own_a();
      t_read_own_b();
      t_refused();
      t_halt();
      t_sw_master();
      results();
   end
endmodule
